//--- bench/dfp_port_monitor.sv
`timescale 1ns/1ns
module dfp_port_monitor (
  input wire        clock,
  input wire        reset,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata_ff,
  input wire [7:0]  count_offset,
  input wire        data_rd,
  input wire [15:0] data_rdata_ff,
  input wire        data_rvalid_ff,
  input wire        packet_count_clear,
  input wire        packet_count_enable,
  input wire        port_width_bit,
  input wire        endpoint_direction,
  input wire        continuous_transfer_mode,
  input wire [1:0]  endpoint_transfer_type,
  input wire        dma_port_selected,
  input wire        sie_packet_ok,
  input wire        rx_complete_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire hit = reg_rd && reg_addr == count_offset;
  wire q = !sie_packet_ok && !packet_count_clear;
  wire ok = !endpoint_direction && continuous_transfer_mode && endpoint_transfer_type == 2'h1 && dma_port_selected;
  a_bad_addr:
    assert property (reg_rd && reg_addr != count_offset |=> reg_rdata_ff == 16'h0000) else $error("stray read");
  a_compare_readback:
    assert property (reg_wr && reg_addr == count_offset && !packet_count_enable ##1 !reg_wr ##1 hit
      && !packet_count_enable && !reg_wr |=> reg_rdata_ff == $past(reg_wdata, 3)) else $error("compare lost");
  a_clear_zero:
    assert property (packet_count_clear && packet_count_enable ##1 q ##1 hit && packet_count_enable && q
      |=> reg_rdata_ff == 16'h0000) else $error("clear failed");
  a_count_steady:
    assert property (hit && packet_count_enable && q ##1 hit && packet_count_enable
      |=> reg_rdata_ff == $past(reg_rdata_ff)) else $error("count drifted");
  a_count_step:
    assert property (hit && packet_count_enable && q ##1 packet_count_enable && sie_packet_ok && !packet_count_clear
      ##1 hit && packet_count_enable && q |=> reg_rdata_ff == $past(reg_rdata_ff, 2) + {15'h0000, $past(ok, 2)})
      else $error("bad count step");
  a_rvalid_cause:
    assert property (data_rvalid_ff |-> $past(data_rd)) else $error("stray read data");
  a_narrow_upper:
    assert property (data_rvalid_ff && $past(port_width_bit) |-> data_rdata_ff[15:8] == 8'h00) else $error("upper set");
  a_complete_enable:
    assert property ($rose(rx_complete_ff) |-> $past(packet_count_enable)) else $error("early complete");
  c_packet: cover property (sie_packet_ok && packet_count_enable && ok);
  c_complete: cover property ($rose(rx_complete_ff));
  c_narrow: cover property (data_rvalid_ff && $past(port_width_bit));
endmodule
bind dfp_port dfp_port_monitor dfp_port_monitor_inst (.*);

//--- bench/dfp_sie_model.sv
`timescale 1ns/1ns
// serial engine stand-in: feeds received words, drains transmit words
module dfp_sie_model (
  input  wire        clock,
  input  wire        reset,
  input  wire        rx_en,
  output reg  [15:0] sie_rx_data,
  output reg         sie_rx_valid,
  input  wire        sie_rx_ready_ff,
  input  wire [15:0] sie_tx_data_ff,
  input  wire        sie_tx_byte_ff,
  input  wire        sie_tx_valid_ff,
  output reg         sie_tx_ready,
  output reg  [7:0]  tx_cnt_ff,
  output reg  [16:0] tx_last_ff
);
  reg [15:0] n_ff;
  // word count advances only when the port takes the word
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      n_ff <= 16'h0000;
    else if (sie_rx_valid && sie_rx_ready_ff)
      n_ff <= n_ff + 16'h0001;
  end
  // idle data line shows the inverse, never a stale word
  always @*
  begin
    sie_rx_valid = rx_en;
    sie_rx_data = rx_en ? 16'ha5c0 + n_ff : ~(16'ha5c0 + n_ff);
  end
  // ready toggles so the port sees stalls
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sie_tx_ready <= 1'b0;
      tx_cnt_ff <= 8'h00;
      tx_last_ff <= 17'h00000;
    end
    else
    begin
      sie_tx_ready <= ~sie_tx_ready;
      if (sie_tx_valid_ff && sie_tx_ready)
      begin
        tx_cnt_ff <= tx_cnt_ff + 8'h01;
        tx_last_ff <= {sie_tx_byte_ff, sie_tx_data_ff};
      end
    end
  end
endmodule

//--- bench/test_dfp_port.sv
`timescale 1ns/1ns
module test_dfp_port;
  reg         clock, reset, reg_wr, reg_rd, data_wr, data_rd, packet_count_clear, packet_count_enable;
  reg         buffer_valid_set, port_width_bit, endpoint_direction, continuous_transfer_mode;
  reg         dma_port_selected, sie_packet_ok, rx_en;
  reg  [7:0]  reg_addr;
  reg  [15:0] reg_wdata, data_wdata;
  reg  [1:0]  data_be, endpoint_transfer_type;
  reg         short_seen_ff = 1'b0;
  wire [7:0]  count_offset = 8'h4e;
  wire        dma_enable_bit = 1'b0, terminal_count_input = 1'b0, bus_width_pin = 1'b0, endpoint_width_control = 1'b0;
  wire [15:0] reg_rdata_ff, data_rdata_ff, sie_tx_data_ff, sie_rx_data;
  wire        data_rvalid_ff, data_wlast_odd_ff, sie_rx_ready_ff, sie_tx_byte_ff, sie_tx_valid_ff, sie_tx_short_ff;
  wire        port_not_ready_ff, buffer_valid_ff, rx_complete_ff, sie_rx_valid, sie_tx_ready;
  wire [10:0] received_length_ff;
  wire [7:0]  tx_cnt_ff;
  wire [16:0] tx_last_ff;
  integer     n_errors = 0, tests_run = 0, i, k;
  dfp_port dfp_port_inst (.*);
  dfp_sie_model dfp_sie_model_inst (.*);
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
    if (sie_tx_short_ff)
      short_seen_ff <= 1'b1;
  task chk(input [16:0] got, input [16:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task wr(input [15:0] d);
  begin
    @(posedge clock) reg_wr <= 1'b1;
    reg_addr <= 8'h4e;
    reg_wdata <= d;
    @(posedge clock) reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [15:0] exp);
  begin
    @(posedge clock) reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock) reg_rd <= 1'b0;
    #1 chk(reg_rdata_ff, exp);
  end
  endtask
  // two reads, one packet, two reads
  task step(input [15:0] exp);
  begin
    @(posedge clock) reg_rd <= 1'b1;
    reg_addr <= 8'h4e;
    @(posedge clock);
    @(posedge clock) reg_rd <= 1'b0;
    sie_packet_ok <= 1'b1;
    @(posedge clock) sie_packet_ok <= 1'b0;
    reg_rd <= 1'b1;
    rd(8'h4e, exp);
  end
  endtask
  task dacc(input w, input [1:0] be, input [15:0] d);
  begin
    i = 0;
    @(posedge clock);
    while (port_not_ready_ff !== 1'b0 && i < 60)
    begin
      i = i + 1;
      @(posedge clock);
    end
    data_wr <= w;
    data_rd <= !w;
    data_be <= be;
    data_wdata <= d;
    @(posedge clock) data_wr <= 1'b0;
    data_rd <= 1'b0;
    #1 if (!w) chk({data_rvalid_ff, data_rdata_ff}, {1'b1, d});
  end
  endtask
  task close_out;
  begin
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    #2000000 n_errors = n_errors + 1;
    close_out;
  end
  initial
  begin
    {reg_wr, reg_rd, data_wr, data_rd, packet_count_clear, packet_count_enable, sie_packet_ok, rx_en} = 8'h00;
    {buffer_valid_set, port_width_bit, endpoint_direction, reg_addr, reg_wdata, data_wdata} = 43'h0;
    {continuous_transfer_mode, dma_port_selected, endpoint_transfer_type, data_be} = 6'h37;
    reset = 1'b1;
    repeat (16) @(posedge clock);
    #1 chk(port_not_ready_ff, 1'b1);
    @(posedge clock) reset <= 1'b0;
    rd(8'h4e, 16'h0000);
    rd(8'h56, 16'h0000);
    wr(16'h0003);
    rd(8'h4e, 16'h0003);
    @(posedge clock) packet_count_enable <= 1'b1;
    @(posedge clock) packet_count_clear <= 1'b1;
    @(posedge clock) packet_count_clear <= 1'b0;
    @(posedge clock);
    rd(8'h4e, 16'h0000);
    for (k = 1; k < 4; k = k + 1)
      step(k);
    chk(rx_complete_ff, 1'b1);
    @(posedge clock) endpoint_transfer_type <= 2'h2;
    step(16'h0003);
    wr(16'h0009);
    rd(8'h4e, 16'h0003);
    @(posedge clock) packet_count_enable <= 1'b0;
    rd(8'h4e, 16'h0009);
    @(posedge clock) rx_en <= 1'b1;
    repeat (30) @(posedge clock);
    for (k = 0; k < 10; k = k + 1)
      dacc(1'b0, 2'h3, 16'ha5c0 + k);
    @(posedge clock) port_width_bit <= 1'b1;
    dacc(1'b0, 2'h3, 16'h00ca);
    @(posedge clock) endpoint_direction <= 1'b1;
    port_width_bit <= 1'b0;
    dacc(1'b1, 2'h3, 16'h1234);
    dacc(1'b1, 2'h1, 16'h55ab);
    chk(data_wlast_odd_ff, 1'b1);
    @(posedge clock) buffer_valid_set <= 1'b1;
    @(posedge clock) buffer_valid_set <= 1'b0;
    for (i = 0; i < 200 && tx_cnt_ff !== 8'h02; i = i + 1)
      @(posedge clock);
    chk({tx_last_ff[16], tx_last_ff[7:0], short_seen_ff}, 17'h357);
    close_out;
  end
endmodule

//--- common/dfp_defines.vh
// Functional notes
// - out endpoint: data port read returns next received word from buffer
// - in endpoint: data port write stores transmit data into buffer
// - 8-bit mode: upper byte ignored on write, reads as zero
// - 16-bit mode detects single-byte writes, odd byte counts possible
// - odd byte then buffer valid or terminal count completes a short packet
// - counter applies only for out, continuous mode, bulk type, dma port access
// - count disabled: count register reads and writes compare value
// - count enabled: reads give current count, writes still load compare
// - count enabled: current count increments per received packet
// - enabled and current equals compare: buffer receive complete
// - count registers zero on hardware reset, kept over soft and bus reset
// - clear bit write of one zeroes current count, reads back zero
// - count enable bit turns counting on when one, off when zero
// - not-ready flag high: no data access, valid and length invalid
// - port is 8-bit if port width bit or endpoint width bits set
`ifndef DFP_DEFINES_VH
`define DFP_DEFINES_VH
`define DFP_OFS_P0_COUNT   8'h4e
`define DFP_OFS_P1_COUNT   8'h56
`define DFP_TYPE_BULK      2'h1
`define DFP_COUNT_RESET    16'h0000
`define DFP_FIFO_DEPTH     8
`define DFP_FIFO_AW        3
`define DFP_WORD_W         17
`endif

//--- design/dfp_fifo.v
`timescale 1ns/1ns
`include "dfp_defines.vh"
module dfp_fifo #(
  parameter W  = `DFP_WORD_W,
  parameter D  = `DFP_FIFO_DEPTH,
  parameter AW = `DFP_FIFO_AW
) (
  input  wire         clock,
  input  wire         reset,
  input  wire         flush,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  localparam [AW:0] FULL_CNT = D;
  reg [W-1:0] mem_ff [0:D-1];
  reg [AW-1:0] wp_ff;
  reg [AW-1:0] rp_ff;
  reg [AW:0]   cnt_ff;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_ff != FULL_CNT);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write
  always @(posedge clock)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data;
  end

  // pointers and fill count
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wp_ff  <= {AW{1'b0}};
      rp_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wp_ff  <= {AW{1'b0}};
      rp_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_ff <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rp_ff <= rp_ff + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

//--- design/dfp_port.v
`timescale 1ns/1ns
`include "dfp_defines.vh"
// one dma data port with packet counter; instantiate twice for ports 0 and 1
module dfp_port (
  input  wire        clock,
  input  wire        reset,
  // register access from host
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata_ff,
  input  wire [7:0]  count_offset,
  // data port strobes
  input  wire        data_wr,
  input  wire        data_rd,
  input  wire [1:0]  data_be,
  input  wire [15:0] data_wdata,
  output reg  [15:0] data_rdata_ff,
  output reg         data_rvalid_ff,
  output reg         data_wlast_odd_ff,
  // control bits from the port control register
  input  wire        packet_count_clear,
  input  wire        packet_count_enable,
  input  wire        dma_enable_bit,
  input  wire        buffer_valid_set,
  input  wire        terminal_count_input,
  input  wire        port_width_bit,
  input  wire        bus_width_pin,
  // endpoint configuration of dma_endpoint_select
  input  wire        endpoint_direction,
  input  wire        continuous_transfer_mode,
  input  wire [1:0]  endpoint_transfer_type,
  input  wire        endpoint_width_control,
  input  wire        dma_port_selected,
  // serial engine side
  input  wire        sie_packet_ok,
  input  wire [15:0] sie_rx_data,
  input  wire        sie_rx_valid,
  output reg         sie_rx_ready_ff,
  output reg  [15:0] sie_tx_data_ff,
  output reg         sie_tx_byte_ff,
  output reg         sie_tx_valid_ff,
  input  wire        sie_tx_ready,
  output reg         sie_tx_short_ff,
  // status
  output reg         port_not_ready_ff,
  output reg         buffer_valid_ff,
  output reg  [10:0] received_length_ff,
  output reg         rx_complete_ff
);
  // -----------------------------------------------------------
  // width and counter qualification
  // -----------------------------------------------------------
  reg [2:0]  pin_sync_ff;
  reg        pin_level_ff;
  reg [15:0] compare_ff;
  reg [15:0] current_packet_count_ff;
  wire       byte_mode;
  wire       count_apply;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [16:0] fifo_out_data;
  wire       fifo_push;
  wire       fifo_pop;
  wire [16:0] fifo_in_word;
  wire       fifo_in_valid;
  wire       count_wr;
  wire       count_rd;
  wire       rx_path;
  wire       odd_write;
  reg        dir_ff;
  wire       dir_change;

  // upper byte masking for 8-bit mode
  function [15:0] dfp_lane;
    input [15:0] d;
    input        narrow;
    begin
      dfp_lane = narrow ? {8'h00, d[7:0]} : d;
    end
  endfunction

  // bus width pin sync, change taken when stages two and three agree
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pin_sync_ff  <= 3'h0;
      pin_level_ff <= 1'b0;
    end
    else
    begin
      pin_sync_ff <= {pin_sync_ff[1:0], bus_width_pin};
      if (pin_sync_ff[2] == pin_sync_ff[1])
        pin_level_ff <= pin_sync_ff[2];
    end
  end

  // direction tracking; a switch empties the buffer and blocks its push and pop for that cycle
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      dir_ff <= 1'b0;
    else
      dir_ff <= endpoint_direction;
  end

  assign dir_change = endpoint_direction ^ dir_ff;

  assign byte_mode = pin_level_ff | port_width_bit | endpoint_width_control;
  assign count_apply = ~endpoint_direction & continuous_transfer_mode &
                       (endpoint_transfer_type == `DFP_TYPE_BULK) & dma_port_selected;
  assign count_wr = reg_wr & (reg_addr == count_offset);
  assign count_rd = reg_rd & (reg_addr == count_offset);
  assign rx_path  = ~endpoint_direction;
  // single byte write in 16-bit mode
  assign odd_write = ~byte_mode & (data_be == 2'h1);

  // -----------------------------------------------------------
  // buffer between host and serial engine
  // -----------------------------------------------------------
  // in: host writes fill buffer
  assign fifo_in_word  = rx_path ? {1'b0, sie_rx_data}
                                 : {byte_mode | odd_write, dfp_lane(data_wdata, byte_mode | odd_write)};
  // receive words are taken only while the advertised ready stands
  assign fifo_in_valid = ~dir_change & (rx_path ? sie_rx_valid & sie_rx_ready_ff
                                                : data_wr & ~port_not_ready_ff);
  assign fifo_pop = ~dir_change & (rx_path ? (data_rd & fifo_out_valid) : (sie_tx_ready | ~sie_tx_valid_ff));
  assign fifo_push = fifo_in_valid & fifo_in_ready;

  dfp_fifo #(
    .W  (`DFP_WORD_W),
    .D  (`DFP_FIFO_DEPTH),
    .AW (`DFP_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .flush     (dir_change),
    .in_data   (fifo_in_word),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // -----------------------------------------------------------
  // data side registers
  // -----------------------------------------------------------
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      data_rdata_ff      <= 16'h0000;
      data_rvalid_ff     <= 1'b0;
      data_wlast_odd_ff  <= 1'b0;
      sie_rx_ready_ff    <= 1'b0;
      sie_tx_data_ff     <= 16'h0000;
      sie_tx_byte_ff     <= 1'b0;
      sie_tx_valid_ff    <= 1'b0;
      sie_tx_short_ff    <= 1'b0;
      port_not_ready_ff  <= 1'b1;
      buffer_valid_ff    <= 1'b0;
      received_length_ff <= 11'h000;
    end
    else
    begin
      data_rvalid_ff <= data_rd & rx_path & fifo_out_valid;
      if (data_rd & rx_path & fifo_out_valid)
        // upper byte invalid in 8-bit mode
        data_rdata_ff <= dfp_lane(fifo_out_data[15:0], byte_mode);
      // ready only after an idle cycle with room, so an accepted word always fits
      sie_rx_ready_ff <= fifo_in_ready & rx_path & dma_port_selected & ~fifo_push & ~dir_change;
      if (fifo_pop & ~rx_path)
      begin
        sie_tx_valid_ff <= fifo_out_valid;
        sie_tx_data_ff  <= fifo_out_data[15:0];
        sie_tx_byte_ff  <= fifo_out_data[16];
      end
      if (data_wr & ~rx_path & fifo_push)
        data_wlast_odd_ff <= odd_write;
      // short packet on buffer valid or terminal count
      sie_tx_short_ff <= ~rx_path & (buffer_valid_set | terminal_count_input);
      // not ready while no data can move
      port_not_ready_ff <= rx_path ? ~fifo_out_valid : ~fifo_in_ready;
      buffer_valid_ff   <= rx_path ? fifo_out_valid : (buffer_valid_set | terminal_count_input);
      if (fifo_push & rx_path & ~fifo_pop)
        received_length_ff <= received_length_ff + 11'h002;
      else if (fifo_pop & rx_path & ~fifo_push & (received_length_ff != 11'h000))
        received_length_ff <= received_length_ff - 11'h002;
    end
  end

  // -----------------------------------------------------------
  // packet counter, hardware reset only
  // -----------------------------------------------------------
  // zero on hardware reset only
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      compare_ff              <= `DFP_COUNT_RESET;
      current_packet_count_ff <= `DFP_COUNT_RESET;
      rx_complete_ff          <= 1'b0;
    end
    else
    begin
      if (count_wr)
        compare_ff <= reg_wdata;
      if (packet_count_clear)
        current_packet_count_ff <= `DFP_COUNT_RESET;
      else if (packet_count_enable & count_apply & sie_packet_ok)
        current_packet_count_ff <= current_packet_count_ff + 16'h0001;
      rx_complete_ff <= packet_count_enable & count_apply &
                        (current_packet_count_ff == compare_ff);
    end
  end

  // register read mux
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      reg_rdata_ff <= 16'h0000;
    else if (count_rd)
      reg_rdata_ff <= packet_count_enable ? current_packet_count_ff : compare_ff;
    else
      reg_rdata_ff <= 16'h0000;
  end
endmodule
